// ### src/plcrs_pkg.sv
package plcrs_pkg;

  // point count and system timing
  localparam int NPTS = 16;
  localparam int CLK_KHZ = 20000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC_DEF = CLK_KHZ * TICK_MS;

  // lamp half periods in milliseconds and in ticks
  localparam int STOP_HALF_MS = 2000;
  localparam int RUN_HALF_MS = 250;
  localparam int ERR_HALF_MS = 500;
  localparam logic [11:0] STOP_HALF_TK = 12'(STOP_HALF_MS / TICK_MS);
  localparam logic [11:0] RUN_HALF_TK = 12'(RUN_HALF_MS / TICK_MS);
  localparam logic [11:0] ERR_HALF_TK = 12'(ERR_HALF_MS / TICK_MS);

  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IN_DIS = 8'h08;
  localparam logic [7:0] OFS_IN_FORCE = 8'h0C;
  localparam logic [7:0] OFS_OUT_DIS = 8'h10;
  localparam logic [7:0] OFS_OUT_FORCE = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
  localparam logic [7:0] OFS_IN_IMAGE = 8'h20;

  // control word bit positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_CLEAR = 2;
  localparam int CTRL_DIS_ALL = 3;
  localparam int CTRL_EN_ALL = 4;

  // interrupt bit positions
  localparam int IRQ_W = 3;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_MODE = 1;
  localparam int IRQ_REFUSE = 2;

  // error code shown on the low output lamps
  localparam int ERR_CODE_BITS = 4;

  // cycles to wait after reset for the pin synchronisers to fill
  localparam logic [1:0] BOOT_SYNC_CYC = 2'h2;

  // reset values
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam logic [NPTS-1:0] PTS_RST = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  typedef enum logic {MODE_STOP, MODE_RUN} plcrs_mode_t;
  typedef enum logic [1:0] {BOOT_WAIT, BOOT_LOAD, BOOT_DONE} plcrs_boot_t;

  typedef struct packed {
    logic evt;
    logic serious;
    logic [3:0] code;
  } plcrs_fault_t;

  typedef struct packed {
    logic [23:0] rsvd;
    logic cartridge;
    logic [3:0] code;
    logic serious;
    logic fault;
    logic running;
  } plcrs_status_t;

endpackage : plcrs_pkg

// ### src/plcrs_blinker.sv
`timescale 1ns/1ps
`default_nettype none
module plcrs_blinker
  import plcrs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic tick_i,
  input wire logic active_i,
  input wire logic steady_i,
  input wire logic [11:0] half_ms_i,
  output logic lamp_o
);

  logic [11:0] ms_cnt_r;
  logic phase_r;
  logic active_q_r;
  logic [11:0] half_q_r;
  logic restart;

  // a new mode restarts the pattern lit, so rate changes show at once
  assign restart = active_i && (!active_q_r || half_ms_i != half_q_r);

  // half period counter driven by the free tick, not by the scan
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ms_cnt_r <= 12'h000;
      phase_r <= 1'b1;
      active_q_r <= 1'b0;
      half_q_r <= 12'h000;
    end else begin
      active_q_r <= active_i;
      half_q_r <= half_ms_i;
      if (!active_i || restart) begin
        ms_cnt_r <= 12'h000;
        phase_r <= 1'b1;
      end else if (tick_i) begin
        if (ms_cnt_r == half_ms_i - 12'h001) begin
          ms_cnt_r <= 12'h000;
          phase_r <= ~phase_r;
        end else begin
          ms_cnt_r <= ms_cnt_r + 12'h001;
        end
      end
    end
  end

  // lamp register: steady wins over blinking
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      lamp_o <= 1'b0;
    end else begin
      lamp_o <= steady_i | (active_i & phase_r);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  chk_half_period: assert property (
    ($changed(phase_r) && $past(active_i) && !$past(restart))
      |-> ($past(tick_i) && $past(ms_cnt_r) == $past(half_ms_i) - 12'h001))
    else $error("blink phase changed before the half period ended");

endmodule : plcrs_blinker
`default_nettype wire

// ### src/plcrs_supervisor.sv
// Functional notes
// - disable or enable points singly or all
// - disabled input image holds forced value
// - disabled output driven only from force
// - forced level applies to point immediately
// - enabled points follow pins and scan again
// - healthy stop: run lamp 2 s on/off
// - run state: run lamp 0.25 s on/off
// - run/stop change only by programmer command
// - commanded run/stop kept over power loss
// - good cartridge forces run at power-up
// - fault forces stop and lights fault lamp
// - minor fault: run resumes after power return
// - serious fault refuses run until cleared
// - power lamp off in low-voltage protection
// - fault lamp dark normally, 0.5 s flash
// - flashing: outputs 0-3 show error code
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module plcrs_supervisor
  import plcrs_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DEF
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  input wire logic [NPTS-1:0] discrete_input_point_i,
  input wire logic [NPTS-1:0] scan_out_i,
  input wire plcrs_fault_t fault_i,
  input wire logic program_cartridge_i,
  input wire logic cartridge_syntax_ok_i,
  input wire logic retained_run_i,
  input wire logic lowv_prot_i,
  output logic [NPTS-1:0] in_image_o,
  output logic [NPTS-1:0] discrete_output_point_o,
  output logic retained_run_o,
  output logic retain_wr_o,
  output logic power_lamp_o,
  output logic run_lamp_o,
  output logic fault_lamp_o,
  output logic irq_o
);

  logic [NPTS-1:0] din_s1_r, din_s2_r;
  logic [3:0] pin_s1_r, pin_s2_r;
  logic cart_ok, ret_run, lowv;
  logic wr_ctrl, run_cmd, stop_cmd, clr_cmd, dis_all, en_all, run_ok;
  plcrs_boot_t boot_r;
  logic [1:0] boot_cnt_r;
  plcrs_mode_t mode_r, mode_d_r;
  logic fault_r, serious_r, flash, boot_done, fault_evt;
  logic [3:0] code_r;
  logic [NPTS-1:0] in_dis_r, in_force_r, out_dis_r, out_force_r;
  logic [IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_ev;
  logic [14:0] tick_cnt_r;
  logic tick_r;
  plcrs_status_t status;

  // pin synchronisers; only the second stage is read by logic
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      din_s1_r <= PTS_RST;
      din_s2_r <= PTS_RST;
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
    end else begin
      din_s1_r <= discrete_input_point_i;
      din_s2_r <= din_s1_r;
      pin_s1_r <= {lowv_prot_i, retained_run_i, cartridge_syntax_ok_i,
                   program_cartridge_i};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign cart_ok = pin_s2_r[0] & pin_s2_r[1];
  assign ret_run = pin_s2_r[2];
  assign lowv = pin_s2_r[3];

  // command decode from the control word
  assign wr_ctrl = reg_we_i && reg_addr_i == OFS_CTRL;
  assign run_cmd = wr_ctrl && reg_wdata_i[CTRL_RUN];
  assign stop_cmd = wr_ctrl && reg_wdata_i[CTRL_STOP];
  assign clr_cmd = wr_ctrl && reg_wdata_i[CTRL_CLEAR];
  assign dis_all = wr_ctrl && reg_wdata_i[CTRL_DIS_ALL];
  assign en_all = wr_ctrl && reg_wdata_i[CTRL_EN_ALL];
  assign boot_done = boot_r == BOOT_DONE;
  assign run_ok = boot_done && run_cmd && !serious_r;
  assign fault_evt = boot_done && fault_i.evt;
  assign flash = fault_r && code_r != 4'h0;

  // boot sequence: strap pins are read only once the synchronisers fill
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      boot_r <= BOOT_WAIT;
      boot_cnt_r <= 2'h0;
    end else begin
      case (boot_r)
        BOOT_WAIT: begin
          boot_cnt_r <= boot_cnt_r + 2'h1;
          if (boot_cnt_r == BOOT_SYNC_CYC - 2'h1) begin
            boot_r <= BOOT_LOAD;
          end
        end
        BOOT_LOAD: boot_r <= BOOT_DONE;
        BOOT_DONE: boot_r <= BOOT_DONE;
        default: boot_r <= BOOT_WAIT;
      endcase
    end
  end

  // operating mode: fault beats stop beats run
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      mode_r <= MODE_STOP;
      mode_d_r <= MODE_STOP;
    end else begin
      mode_d_r <= mode_r;
      if (boot_r == BOOT_LOAD) begin
        mode_r <= (cart_ok || ret_run) ? MODE_RUN : MODE_STOP;
      end else if (fault_evt) begin
        mode_r <= MODE_STOP;
      end else if (boot_done && stop_cmd) begin
        mode_r <= MODE_STOP;
      end else if (run_ok) begin
        mode_r <= MODE_RUN;
      end
    end
  end

  // retained state: a minor fault leaves the stored run in place
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      retained_run_o <= 1'b0;
      retain_wr_o <= 1'b0;
    end else begin
      retain_wr_o <= 1'b0;
      if (boot_r == BOOT_LOAD) begin
        retained_run_o <= ret_run;
      end else if (fault_evt) begin
        if (fault_i.serious) begin
          retained_run_o <= 1'b0;
          retain_wr_o <= 1'b1;
        end
      end else if (boot_done && stop_cmd) begin
        retained_run_o <= 1'b0;
        retain_wr_o <= 1'b1;
      end else if (run_ok) begin
        retained_run_o <= 1'b1;
        retain_wr_o <= 1'b1;
      end
    end
  end

  // fault record; a new fault wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      fault_r <= 1'b0;
      serious_r <= 1'b0;
      code_r <= 4'h0;
    end else if (fault_evt) begin
      fault_r <= 1'b1;
      serious_r <= serious_r | fault_i.serious;
      code_r <= fault_i.code;
    end else if (clr_cmd) begin
      fault_r <= 1'b0;
      serious_r <= 1'b0;
      code_r <= 4'h0;
    end else if (run_ok) begin
      fault_r <= 1'b0;
      code_r <= 4'h0;
    end
  end

  // disable flags, cleared at reset so every point starts enabled
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      in_dis_r <= PTS_RST;
      out_dis_r <= PTS_RST;
    end else if (dis_all) begin
      in_dis_r <= '1;
      out_dis_r <= '1;
    end else if (en_all) begin
      in_dis_r <= PTS_RST;
      out_dis_r <= PTS_RST;
    end else if (reg_we_i && reg_addr_i == OFS_IN_DIS) begin
      in_dis_r <= reg_wdata_i[NPTS-1:0];
    end else if (reg_we_i && reg_addr_i == OFS_OUT_DIS) begin
      out_dis_r <= reg_wdata_i[NPTS-1:0];
    end
  end

  // forced levels
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      in_force_r <= PTS_RST;
      out_force_r <= PTS_RST;
    end else if (reg_we_i && reg_addr_i == OFS_IN_FORCE) begin
      in_force_r <= reg_wdata_i[NPTS-1:0];
    end else if (reg_we_i && reg_addr_i == OFS_OUT_FORCE) begin
      out_force_r <= reg_wdata_i[NPTS-1:0];
    end
  end

  // per point image and drive; the low lamps carry the error code
  for (genvar i = 0; i < NPTS; i++) begin : g_pt
    always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
        in_image_o[i] <= 1'b0;
      end else begin
        in_image_o[i] <= in_dis_r[i] ? in_force_r[i] : din_s2_r[i];
      end
    end
    if (i < ERR_CODE_BITS) begin : g_code
      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          discrete_output_point_o[i] <= 1'b0;
        end else if (flash) begin
          discrete_output_point_o[i] <= code_r[i];
        end else begin
          discrete_output_point_o[i] <= out_dis_r[i] ? out_force_r[i]
                                                     : scan_out_i[i];
        end
      end
    end else begin : g_plain
      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          discrete_output_point_o[i] <= 1'b0;
        end else begin
          discrete_output_point_o[i] <= out_dis_r[i] ? out_force_r[i]
                                                     : scan_out_i[i];
        end
      end
    end
  end

  // power lamp follows the synchronised protection pin
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      power_lamp_o <= 1'b0;
    end else begin
      power_lamp_o <= !lowv;
    end
  end

  // free millisecond tick, independent of the scan time
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      tick_cnt_r <= 15'h0000;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == 15'(TICK_CYC - 1)) begin
      tick_cnt_r <= 15'h0000;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 15'h0001;
      tick_r <= 1'b0;
    end
  end

  // run lamp dark while a fault stands; rate picked by the mode
  plcrs_blinker u_run_lamp (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .tick_i(tick_r),
    .active_i(boot_done && !fault_r),
    .steady_i(1'b0),
    .half_ms_i(mode_r == MODE_RUN ? RUN_HALF_TK : STOP_HALF_TK),
    .lamp_o(run_lamp_o)
  );

  // fault lamp: steady for a plain fault, flashing with an error code
  plcrs_blinker u_fault_lamp (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .tick_i(tick_r),
    .active_i(flash),
    .steady_i(fault_r && !flash),
    .half_ms_i(ERR_HALF_TK),
    .lamp_o(fault_lamp_o)
  );

  // sticky events, set wins over the write-one clear
  assign irq_ev = {run_cmd && boot_done && serious_r, mode_r != mode_d_r,
                   fault_evt};
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      irq_stat_r <= IRQ_RST;
      irq_mask_r <= IRQ_RST;
      irq_o <= 1'b0;
    end else begin
      if (reg_we_i && reg_addr_i == OFS_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~reg_wdata_i[IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_stat_r <= irq_stat_r | irq_ev;
      end
      if (reg_we_i && reg_addr_i == OFS_IRQ_MASK) begin
        irq_mask_r <= reg_wdata_i[IRQ_W-1:0];
      end
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  // status word
  always_comb begin
    status = '0;
    status.running = mode_r == MODE_RUN;
    status.fault = fault_r;
    status.serious = serious_r;
    status.code = code_r;
    status.cartridge = cart_ok;
  end

  // read data stand for one cycle only; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= RDATA_RST;
    end else if (reg_re_i) begin
      case (reg_addr_i)
        OFS_STATUS: reg_rdata_o <= status;
        OFS_IN_DIS: reg_rdata_o <= {16'h0000, in_dis_r};
        OFS_IN_FORCE: reg_rdata_o <= {16'h0000, in_force_r};
        OFS_OUT_DIS: reg_rdata_o <= {16'h0000, out_dis_r};
        OFS_OUT_FORCE: reg_rdata_o <= {16'h0000, out_force_r};
        OFS_IRQ_STAT: reg_rdata_o <= {29'h0000_0000, irq_stat_r};
        OFS_IRQ_MASK: reg_rdata_o <= {29'h0000_0000, irq_mask_r};
        OFS_IN_IMAGE: reg_rdata_o <= {16'h0000, in_image_o};
        default: reg_rdata_o <= RDATA_RST;
      endcase
    end else begin
      reg_rdata_o <= RDATA_RST;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  chk_all_disable: assert property (dis_all |=>
    (in_dis_r == 16'hFFFF && out_dis_r == 16'hFFFF))
    else $error("disable-all did not disable every point");
  chk_in_hold: assert property (in_dis_r[0] |=>
    in_image_o[0] == $past(in_force_r[0]))
    else $error("disabled input image did not take forced value");
  chk_in_follow: assert property (!in_dis_r[0] |=>
    in_image_o[0] == $past(din_s2_r[0]))
    else $error("enabled input image did not follow the pin");
  chk_out_force: assert property (out_dis_r[15] |=>
    discrete_output_point_o[15] == $past(out_force_r[15]))
    else $error("disabled output not driven from force");
  chk_out_scan: assert property (!out_dis_r[15] |=>
    discrete_output_point_o[15] == $past(scan_out_i[15]))
    else $error("enabled output not driven from scan");
  chk_force_now: assert property (
    (reg_we_i && reg_addr_i == OFS_OUT_FORCE && out_dis_r[15]
     && !dis_all) |=> ##1 discrete_output_point_o[15] == $past(reg_wdata_i[15], 2))
    else $error("forced output level not applied at once");
  chk_no_self_run: assert property (
    (boot_done && mode_r == MODE_STOP && !run_ok) |=> mode_r == MODE_STOP)
    else $error("mode left stop without a run command");
  chk_boot_cart: assert property (
    (boot_r == BOOT_LOAD && cart_ok) |=> mode_r == MODE_RUN)
    else $error("good cartridge did not start in run");
  chk_stop_fault: assert property (fault_evt |=>
    (mode_r == MODE_STOP && fault_r) ##1 fault_lamp_o)
    else $error("fault did not stop and light the fault lamp");
  chk_serious_refuse: assert property (
    (serious_r && run_cmd) |=> mode_r == MODE_STOP)
    else $error("run accepted while a serious fault stands");
  chk_lamp_dark: assert property (!$past(fault_r) |-> !fault_lamp_o)
    else $error("fault lamp lit without a fault");
  chk_err_code: assert property (flash |=>
    discrete_output_point_o[3:0] == $past(code_r))
    else $error("error code not shown on low outputs");
  chk_power_lamp: assert property (lowv_prot_i [*3] |=> !power_lamp_o)
    else $error("power lamp lit in low-voltage protection");

  cov_cart_run: cover property (boot_r == BOOT_LOAD && cart_ok ##1 tick_r);
  cov_code_flash: cover property (flash ##1 run_cmd);
  cov_refused: cover property (serious_r && run_cmd);
  cov_dis_all: cover property (dis_all ##1 en_all);

endmodule : plcrs_supervisor
`default_nettype wire

// ### tb/plcrs_store_model.sv
`timescale 1ns/1ps
`default_nettype none
// battery-backed run/stop store beside the block
module plcrs_store_model (
  input wire logic clk_i,
  input wire logic wr_i,
  input wire logic val_i,
  output logic run_o
);
  // no reset on purpose: the contents outlive every power cycle
  initial run_o = 1'b0;
  // a stored value changes only on the block's write strobe
  always @(posedge clk_i) begin
    if (wr_i) begin
      run_o <= val_i;
    end
  end
endmodule : plcrs_store_model
`default_nettype wire

// ### tb/plc_run_state_and_io_override_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module plc_run_state_and_io_override_test;
  import plcrs_pkg::*;
  // short tick keeps the long lamp periods inside the run budget
  localparam int TK = 4;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [NPTS-1:0] pins = 16'h0000;
  logic [NPTS-1:0] scan = 16'h0000;
  plcrs_fault_t flt = '0;
  logic cart = 1'b0;
  logic synok = 1'b0;
  logic lowv = 1'b0;
  logic [31:0] rdata;
  logic [31:0] r;
  logic [NPTS-1:0] image;
  logic [NPTS-1:0] dout;
  logic st_run;
  logic st_wr;
  logic st_val;
  logic power_lamp;
  logic rlamp;
  logic flamp;
  logic irq;
  int failures = 0;
  int tests_run = 0;
  int n;

  // 20 MHz system clock
  always #25 clk_i = ~clk_i;

  plcrs_supervisor #(.TICK_CYC(TK)) uut (
    .clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .discrete_input_point_i(pins),
    .scan_out_i(scan), .fault_i(flt), .program_cartridge_i(cart),
    .cartridge_syntax_ok_i(synok), .retained_run_i(st_run),
    .lowv_prot_i(lowv), .in_image_o(image),
    .discrete_output_point_o(dout), .retained_run_o(st_val),
    .retain_wr_o(st_wr), .power_lamp_o(power_lamp), .run_lamp_o(rlamp),
    .fault_lamp_o(flamp), .irq_o(irq)
  );

  plcrs_store_model store (
    .clk_i(clk_i), .wr_i(st_wr), .val_i(st_val), .run_o(st_run)
  );

  task finish_test;
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  // one-cycle write strobe; the slave never stalls
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk_i);
    we <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task chk_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr <= a;
    re <= 1'b1;
    @(posedge clk_i);
    re <= 1'b0;
    #1;
    r = rdata;
    `CHK(r, e)
  endtask : chk_rd

  // power cycle: straps stay still across it
  task boot;
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    #1;
  endtask : boot

  task setp(input logic [15:0] p, input logic [15:0] s);
    @(posedge clk_i);
    pins <= p;
    scan <= s;
    repeat (4) @(posedge clk_i);
    #1;
  endtask : setp

  task fault(input logic s, input logic [3:0] c);
    @(posedge clk_i);
    flt <= '{evt: 1'b1, serious: s, code: c};
    @(posedge clk_i);
    flt <= '0;
    @(posedge clk_i);
    #1;
  endtask : fault

  // length of one lamp level, from one change to the next
  task meas(input logic sel, output int cnt);
    logic v;
    int i;
    i = 0;
    v = sel ? flamp : rlamp;
    while ((sel ? flamp : rlamp) === v && i < 20000) begin
      @(posedge clk_i);
      #1;
      i++;
    end
    if (i >= 20000) begin
      failures++;
      finish_test();
    end
    v = sel ? flamp : rlamp;
    cnt = 0;
    while ((sel ? flamp : rlamp) === v && cnt < 20000) begin
      @(posedge clk_i);
      #1;
      cnt++;
    end
    if (cnt >= 20000) begin
      failures++;
      finish_test();
    end
  endtask : meas

  // status word: b0 running, b1 fault, b2 serious, b6:3 code, b7 cartridge
  initial begin
    boot();
    chk_rd(OFS_IN_DIS, 32'h0);
    chk_rd(OFS_OUT_FORCE, 32'h0);
    `CHK(power_lamp, 1'b1)
    chk_rd(OFS_STATUS, 32'h00);
    meas(1'b0, n);
    `CHK(n, int'(STOP_HALF_TK) * TK)
    $display("test stop_lamp done");
    setp(16'h1234, 16'hA5A5);
    `CHK(image, 16'h1234)
    `CHK(dout, 16'hA5A5)
    wr(OFS_IN_FORCE, 32'hAB00);
    wr(OFS_IN_DIS, 32'hFF00);
    wr(OFS_OUT_FORCE, 32'h00FF);
    wr(OFS_OUT_DIS, 32'h0F0F);
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(image, 16'hAB34)
    `CHK(dout, 16'hA0AF)
    setp(16'hEDCB, 16'h5A5A);
    `CHK(image, 16'hABCB)
    `CHK(dout, 16'h505F)
    chk_rd(OFS_IN_IMAGE, 32'hABCB);
    wr(OFS_CTRL, 32'h8);
    chk_rd(OFS_OUT_DIS, 32'hFFFF);
    `CHK(dout, 16'h00FF)
    // a forced level on a disabled high output shows two edges on
    wr(OFS_OUT_FORCE, 32'h80FF);
    @(posedge clk_i);
    #1;
    `CHK(dout, 16'h80FF)
    `CHK(image, 16'hAB00)
    wr(OFS_CTRL, 32'h10);
    chk_rd(OFS_IN_DIS, 32'h0);
    `CHK(dout, 16'h5A5A)
    `CHK(image, 16'hEDCB)
    $display("test points done");
    wr(OFS_IRQ_MASK, 32'h7);
    wr(OFS_CTRL, 32'h1);
    repeat (3) @(posedge clk_i);
    #1;
    `CHK(irq, 1'b1)
    `CHK(st_run, 1'b1)
    chk_rd(OFS_IRQ_STAT, 32'h2);
    wr(OFS_IRQ_STAT, 32'h2);
    repeat (50) @(posedge clk_i);
    #1;
    `CHK(irq, 1'b0)
    chk_rd(OFS_STATUS, 32'h01);
    meas(1'b0, n);
    `CHK(n, int'(RUN_HALF_TK) * TK)
    boot();
    chk_rd(OFS_STATUS, 32'h01);
    $display("test run_retain done");
    fault(1'b0, 4'h5);
    `CHK(flamp, 1'b1)
    `CHK(dout[3:0], 4'h5)
    chk_rd(OFS_STATUS, 32'h2A);
    meas(1'b1, n);
    `CHK(n, int'(ERR_HALF_TK) * TK)
    boot();
    chk_rd(OFS_STATUS, 32'h01);
    `CHK(flamp, 1'b0)
    $display("test minor_fault done");
    fault(1'b1, 4'h0);
    `CHK(flamp, 1'b1)
    wr(OFS_CTRL, 32'h1);
    chk_rd(OFS_STATUS, 32'h06);
    chk_rd(OFS_IRQ_STAT, 32'h7);
    wr(OFS_CTRL, 32'h4);
    wr(OFS_CTRL, 32'h1);
    chk_rd(OFS_STATUS, 32'h01);
    wr(OFS_CTRL, 32'h2);
    chk_rd(OFS_STATUS, 32'h00);
    $display("test serious_fault done");
    // a failed syntax check leaves the stored stop in force
    @(posedge clk_i);
    cart <= 1'b1;
    boot();
    chk_rd(OFS_STATUS, 32'h00);
    @(posedge clk_i);
    synok <= 1'b1;
    boot();
    chk_rd(OFS_STATUS, 32'h81);
    $display("test cartridge done");
    @(posedge clk_i);
    lowv <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    `CHK(power_lamp, 1'b0)
    @(posedge clk_i);
    lowv <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    `CHK(power_lamp, 1'b1)
    chk_rd(8'h3C, 32'h0);
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    chk_rd(OFS_STATUS, 32'h81);
    $display("test power_and_map done");
    finish_test();
  end
endmodule : plc_run_state_and_io_override_test
`default_nettype wire
